// [rtl/down_timer_with_pwm.sv]
// Functional notes
// (R1) count register read returns low eight bits of the 10-bit counter
// (R2) count write stores reload low byte, loads counter from full reload
// (R3) counter decrements only while count enable bit 0 is set
// (R4) reload select is ignored in one-shot mode
// (R5) non-stop, reload select 0: underflow reloads 0x3FF
// (R6) non-stop, reload select 1: underflow reloads programmed reload value
// (R7) one-shot: count down to zero once, then stop
// (R8) polarity bit: 0 active high, 1 active low PWM
// (R9) pin enable 1 drives PWM onto pin, 0 leaves pin as GPIO
// (R10) prescale codes 000..111 divide by 2 up to 256
// (R11) prescale disable bit 1 bypasses prescaler, 0 inserts it
// (R12) software changes prescale select only while prescaler disabled
// (R13) external edge select: 1 falling, 0 rising edge counts
// (R14) clock source: 1 external pin, 0 instruction clock
// (R15) PWM frame period follows the 10-bit reload value
// (R16) PWM duty is shared high bits [3:2] over duty byte
// (R17) PWM active while counter at or below duty value
// (R18) each underflow gives a one-cycle event usable as interrupt
`timescale 1ns/1ps
`include "down_timer_regs.svh"

module down_timer_with_pwm #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk, // bus and instruction clock
  input wire logic presetn, // asynchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped index
  input wire logic ext_count_clock_pin, // external count clock pin
  input wire logic gpio_out, // port logic pin data
  input wire logic gpio_oe_n, // port logic pin enable, low drives
  output logic pwm_port_pin_out, // pin data
  output logic pwm_port_pin_oe_n, // pin enable, low drives
  output logic underflow_pulse, // one cycle per underflow
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // state and bus decode
  // ----------------------------------------------------------------
  down_timer_pkg::timer_state_t state_ff;
  down_timer_pkg::timer_state_t nxt_state;

  logic [5:0] idx;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic ext_edge;
  logic src_pulse;
  logic [7:0] presc_mask;
  logic tick;
  logic uf;
  logic cnt_wr;
  logic [9:0] reload_val;
  logic [9:0] duty_val;
  logic pwm_act;
  logic [31:0] rd_val;

  assign idx = paddr[7:2];
  assign wr_acc = psel & penable & pwrite & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;

  // decode of the mapped indices
  always_comb
  begin
    case (idx)
      `IDX_TIMER_COUNT_LOW,
      `IDX_TIMER_CONTROL_ONE,
      `IDX_TIMER_CONTROL_TWO,
      `IDX_PWM_DUTY_LOW,
      `IDX_SHARED_HIGH_BITS,
      `IDX_IRQ_STATUS,
      `IDX_IRQ_CLEAR,
      `IDX_IRQ_ENABLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = state_ff.prdata;

  // ----------------------------------------------------------------
  // count clock path
  // ----------------------------------------------------------------
  // edge seen only on the second synchroniser stage and its delayed copy
  assign ext_edge = state_ff.edge_sel ? (state_ff.ext_prev & ~state_ff.ext_s2) // R13
                                      : (~state_ff.ext_prev & state_ff.ext_s2);
  assign src_pulse = state_ff.clk_src ? ext_edge : 1'b1; // R14
  // division by 2 << select: mask covers the low select+1 bits
  assign presc_mask = 8'hFF >> (3'd7 - state_ff.presc_sel); // R10
  // bypass when the disable bit is high
  assign tick = state_ff.presc_dis_n ? src_pulse // R11
                                     : (src_pulse & ((state_ff.presc & presc_mask) == 8'h00));

  // ----------------------------------------------------------------
  // counter values and PWM compare
  // ----------------------------------------------------------------
  assign cnt_wr = wr_acc & (idx == `IDX_TIMER_COUNT_LOW);
  assign reload_val = {state_ff.high_bits[`HB_RELOAD_HI], state_ff.reload_low}; // R15
  assign duty_val = {state_ff.high_bits[`HB_DUTY_HI], state_ff.duty_low}; // R16
  // a write to the count register takes priority over a tick
  assign uf = tick & state_ff.count_en & ~state_ff.stopped & ~cnt_wr
              & (state_ff.cnt == 10'h000); // R18
  // frame restarts at reload, so duty compare sets the active share
  assign pwm_act = (state_ff.cnt <= duty_val); // R17

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // write-only locations and reserved bits read as zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (idx)
      `IDX_TIMER_COUNT_LOW: rd_val[7:0] = state_ff.cnt[7:0]; // R1
      `IDX_TIMER_CONTROL_ONE:
      begin
        rd_val[`C1_PWM_PIN_ENABLE] = state_ff.pin_en;
        rd_val[`C1_PWM_ACTIVE_LOW] = state_ff.act_low;
        rd_val[`C1_ONE_SHOT_SELECT] = state_ff.one_shot;
        rd_val[`C1_RELOAD_SELECT] = state_ff.reload_sel;
        rd_val[`C1_COUNT_ENABLE] = state_ff.count_en;
      end
      `IDX_TIMER_CONTROL_TWO:
      begin
        rd_val[`C2_CLOCK_SOURCE_SELECT] = state_ff.clk_src;
        rd_val[`C2_EXT_EDGE_SELECT] = state_ff.edge_sel;
        rd_val[`C2_PRESCALE_DISABLE_N] = state_ff.presc_dis_n;
        rd_val[2:0] = state_ff.presc_sel;
      end
      `IDX_SHARED_HIGH_BITS: rd_val[7:0] = state_ff.high_bits;
      `IDX_IRQ_STATUS: rd_val[`IRQ_UNDERFLOW] = state_ff.irq_status;
      `IDX_IRQ_ENABLE: rd_val[`IRQ_UNDERFLOW] = state_ff.irq_en;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    // pin synchroniser: first stage feeds the second only
    nxt_state.ext_s1 = ext_count_clock_pin;
    nxt_state.ext_s2 = state_ff.ext_s1;
    nxt_state.ext_prev = state_ff.ext_s2;

    // register writes
    if (wr_acc)
    begin
      case (idx)
        `IDX_TIMER_CONTROL_ONE:
        begin
          nxt_state.pin_en = pwdata[`C1_PWM_PIN_ENABLE];
          nxt_state.act_low = pwdata[`C1_PWM_ACTIVE_LOW];
          nxt_state.one_shot = pwdata[`C1_ONE_SHOT_SELECT];
          nxt_state.reload_sel = pwdata[`C1_RELOAD_SELECT];
          nxt_state.count_en = pwdata[`C1_COUNT_ENABLE];
        end
        `IDX_TIMER_CONTROL_TWO:
        begin
          nxt_state.clk_src = pwdata[`C2_CLOCK_SOURCE_SELECT];
          nxt_state.edge_sel = pwdata[`C2_EXT_EDGE_SELECT];
          nxt_state.presc_dis_n = pwdata[`C2_PRESCALE_DISABLE_N];
          // no guard here: changing select while enabled may misfire (R12)
          nxt_state.presc_sel = pwdata[2:0];
        end
        `IDX_PWM_DUTY_LOW: nxt_state.duty_low = pwdata[7:0];
        `IDX_SHARED_HIGH_BITS: nxt_state.high_bits = pwdata[7:0];
        `IDX_IRQ_ENABLE: nxt_state.irq_en = pwdata[`IRQ_UNDERFLOW];
        default: nxt_state.irq_en = state_ff.irq_en;
      endcase
    end

    // prescaler: idles at all ones while bypassed
    if (state_ff.presc_dis_n)
    begin
      nxt_state.presc = `RST_PRESCALER;
    end
    else if (src_pulse)
    begin
      nxt_state.presc = state_ff.presc - 8'h01;
    end

    // down counter
    if (cnt_wr)
    begin
      nxt_state.reload_low = pwdata[7:0]; // R2
      nxt_state.cnt = {state_ff.high_bits[`HB_RELOAD_HI], pwdata[7:0]}; // R2
      nxt_state.stopped = 1'b0;
    end
    else if (tick & state_ff.count_en & ~state_ff.stopped) // R3
    begin
      if (state_ff.cnt != 10'h000)
      begin
        nxt_state.cnt = state_ff.cnt - 10'h001;
      end
      else if (state_ff.one_shot) // R4
      begin
        nxt_state.stopped = 1'b1; // R7
      end
      else if (state_ff.reload_sel)
      begin
        nxt_state.cnt = reload_val; // R6
      end
      else
      begin
        nxt_state.cnt = `RELOAD_MAX; // R5
      end
    end

    // sticky status: a new underflow beats a clear in the same cycle
    if (wr_acc & (idx == `IDX_IRQ_CLEAR) & pwdata[`IRQ_UNDERFLOW])
    begin
      nxt_state.irq_status = 1'b0;
    end
    if (uf)
    begin
      nxt_state.irq_status = 1'b1; // R18
    end
    nxt_state.uf_pulse = uf; // R18

    // read data captured in setup, held through access
    if (rd_setup)
    begin
      nxt_state.prdata = rd_val;
    end

    // pin mux, registered to keep glitches off the pad
    if (state_ff.pin_en) // R9
    begin
      nxt_state.pin_out = pwm_act ^ state_ff.act_low; // R8
      nxt_state.pin_oe_n = 1'b0;
    end
    else
    begin
      nxt_state.pin_out = gpio_out;
      nxt_state.pin_oe_n = gpio_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= '0;
      state_ff.clk_src <= 1'b1;
      state_ff.edge_sel <= 1'b1;
      state_ff.presc_dis_n <= 1'b1;
      state_ff.presc_sel <= 3'h7;
      state_ff.presc <= `RST_PRESCALER;
      state_ff.pin_oe_n <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // pin and underflow outputs straight from flip-flops; irq is status AND enable
  assign pwm_port_pin_out = state_ff.pin_out;
  assign pwm_port_pin_oe_n = state_ff.pin_oe_n;
  assign underflow_pulse = state_ff.uf_pulse;
  assign irq = state_ff.irq_status & state_ff.irq_en;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_read_low;
    psel & penable & ~pwrite & (idx == `IDX_TIMER_COUNT_LOW) & $past(rd_setup)
      |-> prdata == {24'h000000, $past(state_ff.cnt[7:0])};
  endproperty
  a_read_low: assert property (p_read_low) // R1
    else $error("count read does not show counter low byte");

  property p_write_load;
    cnt_wr |=> (state_ff.cnt == {$past(state_ff.high_bits[7:6]), $past(pwdata[7:0])})
      && (state_ff.reload_low == $past(pwdata[7:0]));
  endproperty
  a_write_load: assert property (p_write_load) // R2
    else $error("count write did not load counter");

  property p_hold_disabled;
    ~state_ff.count_en & ~cnt_wr |=> $stable(state_ff.cnt);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) // R3
    else $error("counter moved while disabled");

  property p_reload_max;
    uf & ~state_ff.one_shot & ~state_ff.reload_sel |=> state_ff.cnt == 10'h3FF;
  endproperty
  a_reload_max: assert property (p_reload_max) // R5
    else $error("underflow did not reload 0x3FF");

  property p_reload_val;
    uf & ~state_ff.one_shot & state_ff.reload_sel |=> state_ff.cnt == $past(reload_val);
  endproperty
  a_reload_val: assert property (p_reload_val) // R6
    else $error("underflow did not reload programmed value");

  property p_one_shot;
    uf & state_ff.one_shot & ~wr_acc |=> state_ff.stopped && (state_ff.cnt == 10'h000);
  endproperty
  a_one_shot: assert property (p_one_shot) // R7
    else $error("one-shot did not stop at zero");

  property p_pwm_level;
    state_ff.pin_en |=> ~pwm_port_pin_oe_n
      && (pwm_port_pin_out == ($past(pwm_act) ^ $past(state_ff.act_low)));
  endproperty
  a_pwm_level: assert property (p_pwm_level) // R8
    else $error("PWM pin level wrong for polarity");

  property p_gpio_pass;
    ~state_ff.pin_en |=> (pwm_port_pin_out == $past(gpio_out))
      && (pwm_port_pin_oe_n == $past(gpio_oe_n));
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) // R9
    else $error("pin not handed to port logic");

  // bypassed prescaler on the instruction clock: one step every cycle
  property p_bypass;
    state_ff.presc_dis_n & ~state_ff.clk_src & state_ff.count_en & ~state_ff.stopped
      & ~cnt_wr & (state_ff.cnt != 10'h000) |=> state_ff.cnt == $past(state_ff.cnt) - 10'h001;
  endproperty
  a_bypass: assert property (p_bypass) // R11
    else $error("prescaler bypass dropped a count");

  property p_irq_event;
    uf |=> underflow_pulse && state_ff.irq_status ##1 ~underflow_pulse | $past(uf);
  endproperty
  a_irq_event: assert property (p_irq_event) // R18
    else $error("underflow event or status missing");

  // no pin edge means no count from the external source
  property p_ext_idle;
    state_ff.clk_src & (state_ff.ext_prev == state_ff.ext_s2) & ~cnt_wr
      |=> $stable(state_ff.cnt);
  endproperty
  a_ext_idle: assert property (p_ext_idle) // R14
    else $error("counter moved without an external edge");

  // a rising pin edge must not count while falling edges are selected
  property p_wrong_edge;
    state_ff.clk_src & state_ff.edge_sel & ~state_ff.ext_prev & state_ff.ext_s2 & ~cnt_wr
      |=> $stable(state_ff.cnt);
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) // R13
    else $error("counter moved on the unselected edge");

  property p_duty_on;
    state_ff.pin_en & ~state_ff.act_low
      & (state_ff.cnt == {state_ff.high_bits[3:2], state_ff.duty_low}) |=> pwm_port_pin_out;
  endproperty
  a_duty_on: assert property (p_duty_on) // R16
    else $error("PWM not active at the duty value");

  // widened by one bit so a full-scale duty cannot wrap to zero
  property p_duty_off;
    state_ff.pin_en & ~state_ff.act_low
      & ({1'b0, state_ff.cnt} == ({1'b0, state_ff.high_bits[3:2], state_ff.duty_low} + 11'h001))
      |=> ~pwm_port_pin_out;
  endproperty
  a_duty_off: assert property (p_duty_off) // R17
    else $error("PWM active above the duty value");

endmodule : down_timer_with_pwm

// [rtl/down_timer_regs.svh]
`ifndef DOWN_TIMER_REGS_SVH
`define DOWN_TIMER_REGS_SVH
// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_TIMER_COUNT_LOW 6'h09
`define IDX_TIMER_CONTROL_ONE 6'h0A
`define IDX_TIMER_CONTROL_TWO 6'h0B
`define IDX_PWM_DUTY_LOW 6'h0C
`define IDX_SHARED_HIGH_BITS 6'h14
`define IDX_IRQ_STATUS 6'h15
`define IDX_IRQ_CLEAR 6'h16
`define IDX_IRQ_ENABLE 6'h17
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define C1_COUNT_ENABLE 0
`define C1_RELOAD_SELECT 1
`define C1_ONE_SHOT_SELECT 2
`define C1_PWM_ACTIVE_LOW 6
`define C1_PWM_PIN_ENABLE 7
`define C2_PRESCALE_DISABLE_N 3
`define C2_EXT_EDGE_SELECT 4
`define C2_CLOCK_SOURCE_SELECT 5
`define HB_RELOAD_HI 7:6
`define HB_DUTY_HI 3:2
`define IRQ_UNDERFLOW 0
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_CONTROL_ONE 8'h00
`define RST_CONTROL_TWO 8'h3F
`define RST_PRESCALER 8'hFF
`define RELOAD_MAX 10'h3FF
`endif

// [rtl/down_timer_pkg.sv]
package down_timer_pkg;
  // ----------------------------------------------------------------
  // complete state of the timer block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_en;
    logic act_low;
    logic one_shot;
    logic reload_sel;
    logic count_en;
    logic clk_src;
    logic edge_sel;
    logic presc_dis_n;
    logic [2:0] presc_sel;
    logic [7:0] reload_low;
    logic [7:0] duty_low;
    logic [7:0] high_bits;
    logic [9:0] cnt;
    logic stopped;
    logic [7:0] presc;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic irq_status;
    logic irq_en;
    logic uf_pulse;
    logic [31:0] prdata;
    logic pin_out;
    logic pin_oe_n;
  } timer_state_t;
endpackage : down_timer_pkg

// [sim/down_timer_with_pwm_test.sv]
`timescale 1ns/1ps
`include "down_timer_regs.svh"

module down_timer_with_pwm_test;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_count_clock_pin = 1'b0;
  logic gpio_out = 1'b0;
  logic gpio_oe_n = 1'b1;
  logic pwm_port_pin_out;
  logic pwm_port_pin_oe_n;
  logic underflow_pulse;
  logic irq;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd;
  logic err;
  logic [5:0] ridx [7] = '{`IDX_TIMER_COUNT_LOW, `IDX_TIMER_CONTROL_ONE, `IDX_TIMER_CONTROL_TWO,
    `IDX_PWM_DUTY_LOW, `IDX_SHARED_HIGH_BITS, `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE};
  logic [7:0] rexp [7] = '{8'h00, `RST_CONTROL_ONE, `RST_CONTROL_TWO, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] phigh [2] = '{8'h00, 8'h44};
  int pper [2] = '{16, 272};
  int pact [2] = '{5, 261};
  logic [7:0] osmode [2] = '{8'h05, 8'h07};

  down_timer_with_pwm down_timer_with_pwm_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_clock_pin(ext_count_clock_pin), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .pwm_port_pin_out(pwm_port_pin_out),
    .pwm_port_pin_oe_n(pwm_port_pin_oe_n), .underflow_pulse(underflow_pulse), .irq(irq)
  );

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // hang guard, well above the longest expected run
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      miscompares++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; an idle edge first so no signal is driven twice in one step
  task apb(input logic is_wr, input logic [5:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task rdchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask : rdchk

  // cycles until the next underflow pulse, capped at max
  task wait_pulse(input int max);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (underflow_pulse !== 1'b1 && n < max);
  endtask : wait_pulse

  // pin-high cycles over a window of whole frames
  task frame(input int len);
    n = 0;
    repeat (len)
    begin
      @(posedge pclk);
      if (pwm_port_pin_out === 1'b1)
        n++;
    end
  endtask : frame

  // ext pin pulse, four cycles high and four low
  task ext_pulse;
    ext_count_clock_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_count_clock_pin <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : ext_pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdchk(ridx[i], rexp[i]);
    apb(1'b0, 6'h00, 8'h00);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
    check({31'h0, pready}, 32'h00000001);
    $display("reset and map test done");
    // counter held while disabled, then full 10-bit reload from high bits
    wr(`IDX_TIMER_CONTROL_TWO, 8'h08);
    wr(`IDX_SHARED_HIGH_BITS, 8'hC0);
    wr(`IDX_TIMER_COUNT_LOW, 8'h25);
    repeat (20) @(posedge pclk);
    rdchk(`IDX_TIMER_COUNT_LOW, 8'h25);
    wr(`IDX_TIMER_CONTROL_ONE, 8'h03);
    wait_pulse(2000);
    wait_pulse(2000);
    check(n, 32'd806);
    wr(`IDX_TIMER_CONTROL_ONE, 8'h01);
    wait_pulse(2000);
    wait_pulse(2000);
    check(n, 32'd1024);
    $display("reload test done");
    // every prescale code, select changed only while bypassed
    wr(`IDX_SHARED_HIGH_BITS, 8'h00);
    wr(`IDX_TIMER_CONTROL_ONE, 8'h03);
    wr(`IDX_TIMER_COUNT_LOW, 8'h10);
    for (int s = 0; s < 8; s++)
    begin
      wr(`IDX_TIMER_CONTROL_TWO, 8'h08 | 8'(s));
      wr(`IDX_TIMER_CONTROL_TWO, 8'(s));
      wait_pulse(5000);
      wait_pulse(5000);
      check(n, 17 * (2 << s));
      wr(`IDX_TIMER_CONTROL_TWO, 8'h08 | 8'(s));
    end
    $display("prescaler test done");
    // one-shot stops at zero whatever the reload select
    wr(`IDX_TIMER_CONTROL_TWO, 8'h08);
    for (int i = 0; i < 2; i++)
    begin
      wr(`IDX_TIMER_CONTROL_ONE, osmode[i]);
      wr(`IDX_TIMER_COUNT_LOW, 8'h08);
      wait_pulse(50);
      wait_pulse(300);
      check(n, 32'd300);
      rdchk(`IDX_TIMER_COUNT_LOW, 8'h00);
    end
    $display("one-shot test done");
    // external pin, rising then falling edges
    wr(`IDX_TIMER_CONTROL_ONE, 8'h00);
    wr(`IDX_TIMER_CONTROL_TWO, 8'h28);
    wr(`IDX_TIMER_COUNT_LOW, 8'h10);
    wr(`IDX_TIMER_CONTROL_ONE, 8'h01);
    repeat (3) ext_pulse();
    repeat (8) @(posedge pclk);
    rdchk(`IDX_TIMER_COUNT_LOW, 8'h0D);
    wr(`IDX_TIMER_CONTROL_TWO, 8'h38);
    repeat (2) ext_pulse();
    repeat (8) @(posedge pclk);
    rdchk(`IDX_TIMER_COUNT_LOW, 8'h0B);
    $display("external clock test done");
    // pwm frame and duty, both polarities, then pin back to port logic
    wr(`IDX_TIMER_CONTROL_TWO, 8'h08);
    for (int i = 0; i < 2; i++)
    begin
      wr(`IDX_SHARED_HIGH_BITS, phigh[i]);
      wr(`IDX_PWM_DUTY_LOW, 8'h04);
      wr(`IDX_TIMER_COUNT_LOW, 8'h0F);
      wr(`IDX_TIMER_CONTROL_ONE, 8'h83);
      repeat (300) @(posedge pclk);
      frame(2 * pper[i]);
      check(n, 2 * pact[i]);
      check({31'h0, pwm_port_pin_oe_n}, 32'h00000000);
      wr(`IDX_TIMER_CONTROL_ONE, 8'hC3);
      repeat (300) @(posedge pclk);
      frame(2 * pper[i]);
      check(n, 2 * (pper[i] - pact[i]));
    end
    wr(`IDX_TIMER_CONTROL_ONE, 8'h03);
    gpio_out <= 1'b1;
    gpio_oe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    check({pwm_port_pin_out, pwm_port_pin_oe_n}, 32'h00000002);
    gpio_out <= 1'b0;
    gpio_oe_n <= 1'b1;
    repeat (4) @(posedge pclk);
    check({pwm_port_pin_out, pwm_port_pin_oe_n}, 32'h00000001);
    $display("pwm test done");
    // sticky status, masked, enabled, cleared; status itself not writable
    wr(`IDX_TIMER_CONTROL_ONE, 8'h00);
    check({31'h0, irq}, 32'h00000000);
    rdchk(`IDX_IRQ_STATUS, 8'h01);
    wr(`IDX_IRQ_ENABLE, 8'h01);
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000001);
    rdchk(`IDX_IRQ_ENABLE, 8'h01);
    wr(`IDX_IRQ_CLEAR, 8'h01);
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    rdchk(`IDX_IRQ_STATUS, 8'h00);
    wr(`IDX_IRQ_STATUS, 8'h01);
    rdchk(`IDX_IRQ_STATUS, 8'h00);
    $display("interrupt test done");
    finish_test();
  end
endmodule : down_timer_with_pwm_test
